// ### cfg_rb_pkg.sv
package cfg_rb_pkg;
  localparam int unsigned WORD_W      = 32;   // port width (x32 mode)
  localparam int unsigned PAY_W       = 128;  // command payload width
  localparam int unsigned PAY_WORDS   = PAY_W / WORD_W;
  localparam int unsigned BLOCKS      = 73;   // blocks per frame
  localparam int unsigned FRAME_WORDS = BLOCKS * PAY_WORDS;
  localparam int unsigned RESP_LAT    = 5;    // command to bus turn, x32
  localparam int unsigned EDGE_GAP    = 1;    // oen edge to valid edge
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned CNT_W       = 9;
  localparam int unsigned FRAME_W     = 32;
  localparam int unsigned ADDR_W      = 16;

  typedef logic [3:0] op_t;
  localparam op_t OP_NOP     = 4'h0;
  localparam op_t OP_CLK_EN  = 4'h1;
  localparam op_t OP_REG_WR  = 4'h2;
  localparam op_t OP_MEM_RD  = 4'h3;
  localparam op_t OP_CLK_DIS = 4'h4;

  // config_unit register that holds the frame address
  localparam logic [ADDR_W-1:0] REG_FRAME = 16'h0010;

  // field positions inside a payload
  localparam int unsigned OP_LO   = 0;    // low-word opcode
  localparam int unsigned ADDR_LO = 16;   // low write address
  localparam int unsigned DATA_LO = 32;   // low write data
  localparam int unsigned OP_HI   = 64;   // high write opcode
  localparam int unsigned ADDR_HI = 80;
  localparam int unsigned DATA_HI = 96;
  localparam int unsigned OP_RD   = 96;   // read opcode in top word

  // populated cell positions of one 128-bit block
  localparam logic [PAY_W-1:0] CELL_MASK =
    128'h7fff_ffff_ffff_fff0_0fff_ffff_ffff_ff00;
  localparam logic [WORD_W-1:0] CELL_SEED = 32'h9e37_79b9;

  typedef enum logic [1:0] {
    P_CLKEN  = 2'h0,
    P_WRITE  = 2'h1,
    P_READ   = 2'h2,
    P_CLKDIS = 2'h3
  } pay_e;
endpackage

// ### cfg_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cfg_port_if;
  logic                           csn_n;
  logic [cfg_rb_pkg::WORD_W-1:0]  dq_in;
  logic [cfg_rb_pkg::WORD_W-1:0]  dq_out;
  logic                           dq_out_en_n;
  logic                           dq_valid;

  modport host (
    output csn_n,
    output dq_in,
    input  dq_out,
    input  dq_out_en_n,
    input  dq_valid
  );
  modport device (
    input  csn_n,
    input  dq_in,
    output dq_out,
    output dq_out_en_n,
    output dq_valid
  );
endinterface
`default_nettype wire

// ### cfg_readback_dev.sv
// Operation
// - read data returns two reads later
// - clock enable turns on stage two
// - clock disable turns off stage two
// - host writes frame address before read
// - register write payload packs two writes
// - read payload opcode in top word
// - frame addressing starts at zero
// - single frame uses fixed command order
// - host drops first two reads, trailing two
// - host lowers chip select on falling edge
// - first word at first rising edge
// - bus turns to output after read
// - dummy read keeps valid low
// - output period is blocks times four plus two
// - later reads return frame with valid
// - each later set writes next address, reads
// - after last frame, disable then two reads
// - read-back only for unencrypted configuration
// - unpopulated cell bits read as zero
// - input and output never valid together
`timescale 1ns/1ps
`default_nettype none
module fifo_buf #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // fifo_buf

module cfg_readback_dev (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic encrypted,
  output logic      clk_stage2_on,
  cfg_port_if.device port
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_LAT  = 3'b001,
    D_LEAD = 3'b011,
    D_XFER = 3'b010,
    D_TAIL = 3'b110
  } dstate_e;

  localparam int unsigned W = cfg_rb_pkg::WORD_W;
  localparam int unsigned C = cfg_rb_pkg::CNT_W;
  localparam int unsigned F = cfg_rb_pkg::FRAME_W;

  dstate_e                  state;
  logic [1:0]               wcnt;
  logic [cfg_rb_pkg::PAY_W-1:0] cmd;
  logic                     cmd_done;
  logic                     enc_s1;
  logic                     enc_s2;
  logic [F-1:0]             frame;
  logic [F-1:0]             pipe0;
  logic [F-1:0]             pipe1;
  logic [F-1:0]             out_frame;
  logic                     v0;
  logic                     v1;
  logic                     out_v;
  logic                     rd_cmd;
  logic                     gen_active;
  logic [C-1:0]             gen_cnt;
  logic [C-1:0]             out_cnt;
  logic [C-1:0]             lat_cnt;
  logic                     f_in_ready;
  logic                     f_out_valid;
  logic [W-1:0]             f_out_data;
  logic                     pop;
  logic                     take;

  // one word of frame data, unpopulated cells forced to zero
  function automatic logic [W-1:0] cell_word(input logic [F-1:0] fr,
                                             input logic [C-1:0] idx);
    logic [cfg_rb_pkg::PAY_W-1:0] m;
    logic [W-1:0]                 raw;
    m   = cfg_rb_pkg::CELL_MASK;
    raw = (fr * cfg_rb_pkg::CELL_SEED) ^ {fr[15:0], 7'h0, idx};
    return raw & m[idx[1:0]*W +: W];
  endfunction

  // inputs are taken only while the bus faces the host
  assign take   = !port.csn_n && (state == D_IDLE);
  assign rd_cmd = cmd_done &&
                  (cmd[cfg_rb_pkg::OP_RD +: 4] == cfg_rb_pkg::OP_MEM_RD);
  assign pop    = (state == D_XFER) && f_out_valid;

  // encryption strap, synchronised
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_s1 <= 1'b1;
      enc_s2 <= 1'b1;
    end else begin
      enc_s1 <= encrypted;
      enc_s2 <= enc_s1;
    end
  end

  // payload assembly, first word is bits 127:96
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt     <= '0;
      cmd      <= '0;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= take && (wcnt == 2'h3);
      if (port.csn_n) begin
        wcnt <= '0;
      end else if (take) begin
        cmd  <= {cmd[cfg_rb_pkg::PAY_W-W-1:0], port.dq_in};
        wcnt <= wcnt + 1'b1;
      end
    end
  end

  // command decode: stage-two clock and frame address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_stage2_on <= 1'b0;
      frame         <= '0;
    end else if (cmd_done) begin
      if (cmd[cfg_rb_pkg::OP_LO +: 4] == cfg_rb_pkg::OP_CLK_EN) begin
        clk_stage2_on <= 1'b1;
      end
      if (cmd[cfg_rb_pkg::OP_LO +: 4] == cfg_rb_pkg::OP_CLK_DIS) begin
        clk_stage2_on <= 1'b0;
      end
      // both halves of a write pair, upper half executes last
      if (cmd[cfg_rb_pkg::OP_LO +: 4] == cfg_rb_pkg::OP_REG_WR &&
          cmd[cfg_rb_pkg::ADDR_LO +: cfg_rb_pkg::ADDR_W] ==
          cfg_rb_pkg::REG_FRAME) begin
        frame <= cmd[cfg_rb_pkg::DATA_LO +: F];
      end
      if (cmd[cfg_rb_pkg::OP_HI +: 4] == cfg_rb_pkg::OP_REG_WR &&
          cmd[cfg_rb_pkg::ADDR_HI +: cfg_rb_pkg::ADDR_W] ==
          cfg_rb_pkg::REG_FRAME) begin
        frame <= cmd[cfg_rb_pkg::DATA_HI +: F];
      end
    end
  end

  // two-stage data register pipe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe0     <= '0;
      pipe1     <= '0;
      out_frame <= '0;
      v0        <= 1'b0;
      v1        <= 1'b0;
      out_v     <= 1'b0;
    end else if (cmd_done &&
                 cmd[cfg_rb_pkg::OP_LO +: 4] == cfg_rb_pkg::OP_CLK_EN) begin
      v0 <= 1'b0; // stale contents flushed
      v1 <= 1'b0;
    end else if (rd_cmd) begin
      out_frame <= pipe1;
      out_v     <= v1 && !enc_s2;
      pipe1     <= pipe0;
      v1        <= v0;
      pipe0     <= frame;
      v0        <= clk_stage2_on;
    end
  end

  // word generator into the buffer, stalls when full
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_active <= 1'b0;
      gen_cnt    <= '0;
    end else if (rd_cmd) begin
      gen_active <= 1'b1;
      gen_cnt    <= '0;
    end else if (gen_active && f_in_ready) begin
      gen_cnt <= gen_cnt + 1'b1;
      if (gen_cnt == C'(cfg_rb_pkg::FRAME_WORDS - 1)) begin
        gen_active <= 1'b0;
      end
    end
  end

  fifo_buf #(
    .WIDTH (W),
    .DEPTH (cfg_rb_pkg::FIFO_DEPTH)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (gen_active),
    .in_ready  (f_in_ready),
    .in_data   (out_v ? cell_word(out_frame, gen_cnt) : '0),
    .out_valid (f_out_valid),
    .out_ready (state == D_XFER),
    .out_data  (f_out_data)
  );

  // bus turn-around and output period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state            <= D_IDLE;
      lat_cnt          <= '0;
      out_cnt          <= '0;
      port.dq_out_en_n <= 1'b1;
      port.dq_valid    <= 1'b0;
      port.dq_out      <= '0;
    end else begin
      port.dq_valid <= pop && out_v;
      port.dq_out   <= (pop && out_v) ? f_out_data : '0;
      case (state)
        D_IDLE: begin
          if (rd_cmd) begin
            state   <= D_LAT;
            lat_cnt <= C'(cfg_rb_pkg::RESP_LAT - 3); // decode and lead edges
          end
        end
        D_LAT: begin
          if (lat_cnt == '0) begin
            state   <= D_LEAD;
            lat_cnt <= C'(cfg_rb_pkg::EDGE_GAP - 1);
          end else begin
            lat_cnt <= lat_cnt - 1'b1;
          end
        end
        // bus turns here, first valid word one edge later
        D_LEAD: begin
          if (lat_cnt == '0) begin
            state            <= D_XFER;
            port.dq_out_en_n <= 1'b0;
            out_cnt          <= '0;
          end else begin
            lat_cnt <= lat_cnt - 1'b1;
          end
        end
        D_XFER: begin
          if (pop) begin
            out_cnt <= out_cnt + 1'b1;
            if (out_cnt == C'(cfg_rb_pkg::FRAME_WORDS - 1)) begin
              state   <= D_TAIL;
              lat_cnt <= C'(cfg_rb_pkg::EDGE_GAP); // last word still shown
            end
          end
        end
        D_TAIL: begin
          if (lat_cnt == '0) begin
            state            <= D_IDLE;
            port.dq_out_en_n <= 1'b1;
          end else begin
            lat_cnt <= lat_cnt - 1'b1;
          end
        end
        default: begin
          state            <= D_IDLE;
          port.dq_out_en_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // cfg_readback_dev
`default_nettype wire

// ### cfg_readback_host.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_readback_host (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              start,
  input  wire logic [cfg_rb_pkg::FRAME_W-1:0]    last_frame,
  output logic                                   busy,
  output logic                                   done,
  output logic      [cfg_rb_pkg::WORD_W-1:0]     rd_data,
  output logic                                   rd_valid,
  cfg_port_if.host                               port
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SEND = 3'b001,
    H_WLO  = 3'b011,
    H_WHI  = 3'b010
  } hstate_e;

  localparam int unsigned W = cfg_rb_pkg::WORD_W;
  localparam int unsigned F = cfg_rb_pkg::FRAME_W;

  hstate_e          state;
  cfg_rb_pkg::pay_e kind;
  logic [1:0]       widx;
  logic [F-1:0]     addr;
  logic [1:0]       trail;
  logic [1:0]       reads;
  logic             active;

  // one payload word, index 0 is bits 127:96
  function automatic logic [W-1:0] pay_word(input cfg_rb_pkg::pay_e k,
                                            input logic [F-1:0] a,
                                            input logic [1:0] i);
    logic [cfg_rb_pkg::PAY_W-1:0] p;
    logic [W-1:0]                 wr;
    p  = '0;
    wr = {cfg_rb_pkg::REG_FRAME, 12'h000, cfg_rb_pkg::OP_REG_WR};
    case (k)
      cfg_rb_pkg::P_CLKEN:  p[3:0] = cfg_rb_pkg::OP_CLK_EN;
      cfg_rb_pkg::P_WRITE:  p = {a, wr, a, wr};
      cfg_rb_pkg::P_READ:   p[99:96] = cfg_rb_pkg::OP_MEM_RD;
      cfg_rb_pkg::P_CLKDIS: p[3:0] = cfg_rb_pkg::OP_CLK_DIS;
      default:              p = '0;
    endcase
    return p[(3 - i) * W +: W];
  endfunction

  // chip select moves on the falling edge
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port.csn_n <= 1'b1;
    end else begin
      port.csn_n <= !active;
    end
  end

  // command sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= H_IDLE;
      kind       <= cfg_rb_pkg::P_CLKEN;
      widx       <= '0;
      addr       <= '0;
      trail      <= '0;
      active     <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
      port.dq_in <= '0;
    end else begin
      done <= 1'b0;
      case (state)
        H_IDLE: begin
          if (start) begin
            state      <= H_SEND;
            kind       <= cfg_rb_pkg::P_CLKEN;
            addr       <= '0;
            trail      <= '0;
            widx       <= '0;
            active     <= 1'b1;
            busy       <= 1'b1;
            port.dq_in <= pay_word(cfg_rb_pkg::P_CLKEN, '0, 2'h0);
          end
        end
        H_SEND: begin
          if (!port.csn_n) begin
            if (widx != 2'h3) begin
              widx       <= widx + 1'b1;
              port.dq_in <= pay_word(kind, addr, widx + 1'b1);
            end else if (kind == cfg_rb_pkg::P_READ) begin
              state      <= H_WLO;
              active     <= 1'b0;
              port.dq_in <= '0;
            end else begin
              widx <= '0;
              if (kind == cfg_rb_pkg::P_CLKEN) begin
                kind       <= cfg_rb_pkg::P_WRITE;
                port.dq_in <= pay_word(cfg_rb_pkg::P_WRITE, addr, 2'h0);
              end else begin
                kind       <= cfg_rb_pkg::P_READ;
                port.dq_in <= pay_word(cfg_rb_pkg::P_READ, addr, 2'h0);
              end
            end
          end
        end
        H_WLO: begin
          if (!port.dq_out_en_n) begin
            state <= H_WHI;
          end
        end
        H_WHI: begin
          if (port.dq_out_en_n) begin
            widx <= '0;
            if (trail == 2'h2) begin
              state <= H_IDLE;
              busy  <= 1'b0;
              done  <= 1'b1;
            end else if (trail == 2'h1) begin
              state      <= H_SEND;
              trail      <= 2'h2;
              active     <= 1'b1;
              port.dq_in <= pay_word(cfg_rb_pkg::P_READ, addr, 2'h0);
            end else if (addr == last_frame) begin
              state      <= H_SEND;
              kind       <= cfg_rb_pkg::P_CLKDIS;
              trail      <= 2'h1;
              active     <= 1'b1;
              port.dq_in <= pay_word(cfg_rb_pkg::P_CLKDIS, addr, 2'h0);
            end else begin
              state      <= H_SEND;
              kind       <= cfg_rb_pkg::P_WRITE;
              addr       <= addr + 1'b1;
              active     <= 1'b1;
              port.dq_in <= pay_word(cfg_rb_pkg::P_WRITE, addr + 1'b1, 2'h0);
            end
          end
        end
        default: begin
          state  <= H_IDLE;
          active <= 1'b0;
        end
      endcase
    end
  end

  // read-back capture, first two reads dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reads    <= '0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      if (start && state == H_IDLE) begin
        reads <= '0;
      end else if (state == H_WHI && port.dq_out_en_n && reads != 2'h2) begin
        reads <= reads + 1'b1;
      end
      rd_valid <= port.dq_valid && reads == 2'h2;
      rd_data  <= port.dq_valid ? port.dq_out : '0;
    end
  end
endmodule // cfg_readback_host
`default_nettype wire

// ### cfg_readback_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_readback_asserts (
  input wire logic                          clk,
  input wire logic                          rst_n,
  input wire logic                          csn_n,
  input wire logic [cfg_rb_pkg::WORD_W-1:0] dq_in,
  input wire logic [cfg_rb_pkg::WORD_W-1:0] dq_out,
  input wire logic                          dq_out_en_n,
  input wire logic                          dq_valid
);
  logic [95:0]  held;
  logic [127:0] full;
  logic [1:0]   wcnt;
  logic [1:0]   rd_num;
  logic [8:0]   lo_cnt;
  logic [8:0]   v_cnt;
  logic         pend;
  logic         take;
  logic         read_end;
  logic         clken_end;

  // payload framing as the device takes words
  assign take      = !csn_n && dq_out_en_n && !pend;
  assign full      = {held, dq_in};
  assign read_end  = take && wcnt == 2'd3 &&
                     full == {28'h0, cfg_rb_pkg::OP_MEM_RD, 96'h0};
  assign clken_end = take && wcnt == 2'd3 &&
                     full == 128'(cfg_rb_pkg::OP_CLK_EN);

  // word count, pending read, reads since clock enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held   <= '0;
      wcnt   <= '0;
      pend   <= 1'b0;
      rd_num <= '0;
    end else begin
      if (csn_n) begin
        wcnt <= '0;
      end else if (take) begin
        wcnt <= wcnt + 2'd1;
        held <= full[95:0];
      end
      if (read_end) begin
        pend <= 1'b1;
      end else if (!dq_out_en_n) begin
        pend <= 1'b0;
      end
      if (clken_end) begin
        rd_num <= '0;
      end else if (read_end && rd_num != 2'd3) begin
        rd_num <= rd_num + 2'd1;
      end
    end
  end

  // lengths of the output period and of the valid run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt <= '0;
      v_cnt  <= '0;
    end else begin
      lo_cnt <= dq_out_en_n ? 9'd0 : lo_cnt + 9'd1;
      v_cnt  <= dq_valid ? v_cnt + 9'd1 : 9'd0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_out_zero; !dq_valid |-> dq_out == '0; endproperty
  property p_in_quiet; !dq_out_en_n |-> csn_n && dq_in == '0; endproperty
  property p_valid_win; dq_valid |-> !dq_out_en_n; endproperty
  property p_turn_lat; read_end |-> ##[3:10] !dq_out_en_n; endproperty
  property p_x_len;
    $rose(dq_out_en_n) |-> lo_cnt inside {9'd294, 9'd295};
  endproperty
  property p_x_max; !dq_out_en_n |-> lo_cnt < 9'd295; endproperty
  property p_valid_run;
    $fell(dq_valid) |-> v_cnt == 9'(cfg_rb_pkg::FRAME_WORDS);
  endproperty
  property p_lead; $fell(dq_out_en_n) |-> !dq_valid; endproperty
  property p_tail; $rose(dq_out_en_n) |-> !$past(dq_valid); endproperty
  property p_dummy; !dq_out_en_n && rd_num != 2'd3 |-> !dq_valid; endproperty

  a_out_zero: assert property (p_out_zero)
    else $error("read data not zero outside valid");
  a_in_quiet: assert property (p_in_quiet)
    else $error("input bus active during output period");
  a_valid_win: assert property (p_valid_win)
    else $error("valid outside output period");
  a_turn_lat: assert property (p_turn_lat)
    else $error("bus turn late after read");
  a_x_len: assert property (p_x_len)
    else $error("output period length wrong");
  a_x_max: assert property (p_x_max)
    else $error("output period too long");
  a_valid_run: assert property (p_valid_run)
    else $error("valid run length wrong");
  a_lead: assert property (p_lead)
    else $error("valid high at bus turn");
  a_tail: assert property (p_tail)
    else $error("valid high before bus release");
  a_dummy: assert property (p_dummy)
    else $error("valid during dummy read");

  c_read: cover property (read_end);
  c_clken: cover property (clken_end);
  c_valid: cover property ($rose(dq_valid));
endmodule // cfg_readback_asserts
`default_nettype wire

// ### test_config_memory_readback.sv
`timescale 1ns/1ps
`default_nettype none
module test_config_memory_readback;
  logic         clk;
  logic         rst_n;
  logic         encrypted;
  logic         clk_stage2_on;
  logic         start;
  logic [31:0]  last_frame;
  logic         busy;
  logic         done;
  logic [31:0]  rd_data;
  logic         rd_valid;
  logic         was_low;
  int           v_words;
  logic [95:0]  held;
  logic [1:0]   wcnt;
  logic         pend;
  int           err_count;
  int           n_compared;
  logic [127:0] exp_pay[$];
  logic [31:0]  exp_word[$];
  int           exp_run[$];

  cfg_port_if port_if ();
  cfg_readback_dev cfg_readback_dev_inst (.clk(clk), .rst_n(rst_n),
    .encrypted(encrypted), .clk_stage2_on(clk_stage2_on), .port(port_if));
  cfg_readback_host cfg_readback_host_inst (.clk(clk), .rst_n(rst_n),
    .start(start), .last_frame(last_frame), .busy(busy), .done(done),
    .rd_data(rd_data), .rd_valid(rd_valid), .port(port_if));
  cfg_readback_asserts cfg_readback_asserts_inst (.clk(clk), .rst_n(rst_n),
    .csn_n(port_if.csn_n), .dq_in(port_if.dq_in), .dq_out(port_if.dq_out),
    .dq_out_en_n(port_if.dq_out_en_n), .dq_valid(port_if.dq_valid));

  // free running clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // command payloads: 0 clk en, 1 frame write, 2 read, 3 clk dis
  function automatic logic [127:0] pay(input int k, input int f);
    logic [63:0] w;
    w = {f[31:0], cfg_rb_pkg::REG_FRAME, 12'h0, cfg_rb_pkg::OP_REG_WR};
    case (k)
      0: return 128'(cfg_rb_pkg::OP_CLK_EN);
      1: return {w, w};
      2: return {28'h0, cfg_rb_pkg::OP_MEM_RD, 96'h0};
      default: return 128'(cfg_rb_pkg::OP_CLK_DIS);
    endcase
  endfunction

  // frame data word with unpopulated cells masked
  function automatic logic [31:0] word(input int f, input int i);
    logic [127:0] m;
    logic [31:0]  fv;
    fv = f;
    m = cfg_rb_pkg::CELL_MASK >> (32 * (i % 4));
    return ((fv * cfg_rb_pkg::CELL_SEED) ^ {fv[15:0], 7'h0, 9'(i)}) & m[31:0];
  endfunction

  // payloads taken by the device against the expected order
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt = '0;
      pend = 1'b0;
    end else begin
      if (!port_if.dq_out_en_n) pend = 1'b0;
      if (port_if.csn_n) begin
        wcnt = '0;
      end else if (port_if.dq_out_en_n && !pend) begin
        if (wcnt == 2'd3) begin
          chk({held, port_if.dq_in},
              exp_pay.size() > 0 ? exp_pay.pop_front() : '1);
          pend = ({held, port_if.dq_in} == pay(2, 0));
        end
        held = {held[63:0], port_if.dq_in};
        wcnt = wcnt + 2'd1;
      end
    end
  end

  // captured read-back words against the frame model
  always @(posedge clk) begin
    if (rst_n && rd_valid) begin
      chk(rd_data, exp_word.size() > 0 ? exp_word.pop_front()
                                       : 128'h1_0000_0000);
    end
  end

  // valid words per output period: buffer drops and repeats nothing
  always @(posedge clk) begin
    if (rst_n && !port_if.dq_out_en_n) begin
      v_words = v_words + int'(port_if.dq_valid);
    end else if (rst_n && was_low) begin
      chk(v_words, exp_run.size() > 0 ? exp_run.pop_front() : -1);
      v_words = 0;
    end
    was_low = rst_n && !port_if.dq_out_en_n;
  end

  // full read-back of frames 0..n, second start while busy
  task automatic run(input int n, input logic enc);
    int i;
    int k;
    int fw;
    @(negedge clk);
    fw = enc ? 0 : cfg_rb_pkg::FRAME_WORDS;
    encrypted = enc;
    last_frame = n;
    repeat (4) @(negedge clk);
    exp_pay.push_back(pay(0, 0));
    for (k = 0; k <= n; k++) begin
      exp_pay.push_back(pay(1, k));
      exp_pay.push_back(pay(2, 0));
    end
    exp_pay.push_back(pay(3, 0));
    exp_pay.push_back(pay(2, 0));
    exp_pay.push_back(pay(2, 0));
    for (k = 0; k <= n && !enc; k++) begin
      for (i = 0; i < cfg_rb_pkg::FRAME_WORDS; i++) begin
        exp_word.push_back(word(k, i));
      end
    end
    for (k = 0; k <= n + 2; k++) begin
      exp_run.push_back(k < 2 ? 0 : fw); // first two periods are dummies
    end
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (20) @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < 60 && port_if.dq_out_en_n; i++) @(negedge clk);
    chk(port_if.dq_out_en_n, 1'b0);
    chk(clk_stage2_on, 1'b1);
    for (i = 0; i < (n + 3) * 400 && !done; i++) @(negedge clk);
    if (!done) begin
      err_count++;
      final_report();
    end
    repeat (4) @(negedge clk);
    chk(clk_stage2_on, 1'b0);
    chk(exp_pay.size(), 0);
    chk(exp_word.size(), 0);
    chk(exp_run.size(), 0);
  endtask

  // idle bus and host after the last run
  task automatic idle_test();
    repeat (2) @(negedge clk);
    chk(port_if.dq_out_en_n, 1'b1);
    chk(port_if.dq_valid, 1'b0);
    chk(port_if.dq_out, '0);
    chk(busy, 1'b0);
  endtask

  // reset, then single frame, multi frame, encrypted run and idle checks
  initial begin
    rst_n = 1'b0;
    encrypted = 1'b0;
    start = 1'b0;
    last_frame = '0;
    was_low = 1'b0;
    v_words = 0;
    err_count = 0;
    n_compared = 0;
    void'($urandom(45));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    run(0, 1'b0);
    run(1 + $urandom % 3, 1'b0);
    run(1, 1'b1);
    idle_test();
    final_report();
  end
endmodule // test_config_memory_readback
`default_nettype wire
